//--- verilog/fault_flags_pkg.sv
/*
 * Constants for the primary fault flag register: offset, reset value,
 * bit positions of every field and the layout of the sticky flags.
 * Assumes a register read port that carries a byte-wide offset.
 */
package fault_flags_pkg;

   // Register decode
   localparam int ADDR_W = 8;
   localparam logic [7:0] FAULT_REG_OFFSET = 8'h03;
   localparam logic [15:0] FAULT_REG_RESET = 16'h0800;
   localparam logic [15:0] RESERVED_MASK = 16'h8050;

   // Field positions
   localparam int BIT_PARITY = 0;
   localparam int BIT_LAST_MSG = 1;
   localparam int BIT_LINK_LOSS = 2;
   localparam int BIT_TRISTATE = 3;
   localparam int BIT_NEG_OV = 5;
   localparam int BIT_VERIFY_TO = 7;
   localparam int BIT_SPI_FAULT = 8;
   localparam int BIT_SHOOT = 9;
   localparam int BIT_ENABLE = 10;
   localparam int BIT_PRIM_RESET = 11;
   localparam int BIT_EXT_RESET = 12;
   localparam int BIT_BLANK_TO = 13;
   localparam int BIT_OV2_TO = 14;

   // Sticky flag slots, index into the sticky vector
   localparam int STICKY_NUM = 6;
   localparam int SK_LINK = 0;
   localparam int SK_SPI = 1;
   localparam int SK_SHOOT = 2;
   localparam int SK_ENABLE = 3;
   localparam int SK_PRIM_RESET = 4;
   localparam int SK_EXT_RESET = 5;
   localparam int STICKY_POS [STICKY_NUM] = '{
      BIT_LINK_LOSS, BIT_SPI_FAULT, BIT_SHOOT,
      BIT_ENABLE, BIT_PRIM_RESET, BIT_EXT_RESET};

   // Mirrored remote flag slots
   localparam int MIRROR_NUM = 5;
   localparam int MR_OV2_TO = 0;
   localparam int MR_BLANK_TO = 1;
   localparam int MR_VERIFY_TO = 2;
   localparam int MR_NEG_OV = 3;
   localparam int MR_TRISTATE = 4;
   localparam int MIRROR_POS [MIRROR_NUM] = '{
      BIT_OV2_TO, BIT_BLANK_TO, BIT_VERIFY_TO,
      BIT_NEG_OV, BIT_TRISTATE};

   // Read answer sequencing
   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_ANSWER = 2'b10
   } rd_state_t;

endpackage : fault_flags_pkg

//--- verilog/odd_parity.sv
/*
 * Odd parity generator for a 16-bit returned word.
 * Assumes bit 0 of the word is the parity slot itself.
 */
`timescale 1ns/1ns

module odd_parity (
   // Upper fifteen bits of the word
   input wire logic [15:1] word,
   // Parity bit making the whole word odd
   output logic parity
);

   // Odd total count of ones over the sixteen bits
   always_comb begin
      parity = ~(^word);
   end

endmodule : odd_parity

//--- verilog/primary_fault_flags.sv
/*
 * Primary fault flag register: sticky primary-side fault flags, mirrors
 * of remote flags, last-message status and odd parity, read at its own
 * offset through a simple read port.
 * Assumes the serial framer issues one-cycle read requests and clear
 * commands, event inputs are one-cycle pulses and all inputs are
 * synchronous to ref_clk.
 */
`timescale 1ns/1ns

module primary_fault_flags (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register read port
   input wire logic rdReq,
   input wire logic [fault_flags_pkg::ADDR_W-1:0] rdAddr,
   output logic [15:0] rdData_q,
   output logic rdValid_q,
   output logic rdMiss_q,
   // Clear command for sticky flags
   input wire logic clearReq,
   // Primary events and conditions
   input wire logic resetEvt,
   input wire logic extResetEvt,
   input wire logic enableValid,
   input wire logic shootThroughEvt,
   input wire logic shootThroughInhibit,
   input wire logic spiFaultEvt,
   input wire logic linkLossEvt,
   input wire logic secondaryReady,
   input wire logic lastMessageInvalid,
   // Remote flags to mirror
   input wire logic overvoltage2TimeoutFlag,
   input wire logic blankingTimeoutFlag,
   input wire logic verifyTimeoutFlag,
   input wire logic negativeSupplyOvervoltageFlag,
   input wire logic outputTristateFlag,
   // Status view
   output logic shootThroughInhibit_q,
   output logic [15:0] faultFlags_q
);

   logic [fault_flags_pkg::STICKY_NUM-1:0] sticky_q;
   logic [fault_flags_pkg::STICKY_NUM-1:0] sticky_d;
   logic [fault_flags_pkg::STICKY_NUM-1:0] stickySet;
   logic [fault_flags_pkg::STICKY_NUM-1:0] clearBlock;
   logic [fault_flags_pkg::MIRROR_NUM-1:0] mirror_q;
   logic [fault_flags_pkg::MIRROR_NUM-1:0] mirror_d;
   logic [fault_flags_pkg::MIRROR_NUM-1:0] mirrorIn;
   logic enableValid_q;
   logic enableValid_d;
   logic lastMsgBad_q;
   logic lastMsgBad_d;
   logic inhibit_d;
   logic anyReset;
   logic [15:0] wordRaw;
   logic wordParity;
   logic [15:0] faultFlags_d;
   fault_flags_pkg::rd_state_t rdState_q;
   fault_flags_pkg::rd_state_t rdState_d;
   logic [15:0] rdData_d;
   logic rdValid_d;
   logic rdMiss_d;

   // Reset sources, internal or from the reset pin
   assign anyReset = resetEvt | extResetEvt;

   // Set causes of each sticky flag
   always_comb begin
      stickySet = '0;
      stickySet[fault_flags_pkg::SK_LINK] =
         linkLossEvt & ~anyReset;
      stickySet[fault_flags_pkg::SK_SPI] = spiFaultEvt;
      stickySet[fault_flags_pkg::SK_SHOOT] = shootThroughEvt;
      stickySet[fault_flags_pkg::SK_ENABLE] =
         enableValid_q & ~enableValid;
      stickySet[fault_flags_pkg::SK_PRIM_RESET] = anyReset;
      stickySet[fault_flags_pkg::SK_EXT_RESET] = extResetEvt;
   end

   // Conditions that keep a flag from clearing
   always_comb begin
      clearBlock = '0;
      clearBlock[fault_flags_pkg::SK_LINK] = ~secondaryReady;
      clearBlock[fault_flags_pkg::SK_SHOOT] =
         shootThroughInhibit;
      clearBlock[fault_flags_pkg::SK_ENABLE] = ~enableValid;
   end

   // One sticky cell per flag; a set in the clear cycle wins
   for (genvar g = 0; g < fault_flags_pkg::STICKY_NUM; g++) begin : gSticky
      always_comb begin
         sticky_d[g] = stickySet[g] |
            (sticky_q[g] & ~(clearReq & ~clearBlock[g]));
      end

      always_ff @(posedge ref_clk) begin
         if (rst) begin
            sticky_q[g] <= fault_flags_pkg::FAULT_REG_RESET[
               fault_flags_pkg::STICKY_POS[g]];
         end else begin
            sticky_q[g] <= sticky_d[g];
         end
      end
   end

   // Remote flags gathered in slot order
   always_comb begin
      mirrorIn = '0;
      mirrorIn[fault_flags_pkg::MR_OV2_TO] = overvoltage2TimeoutFlag;
      mirrorIn[fault_flags_pkg::MR_BLANK_TO] = blankingTimeoutFlag;
      mirrorIn[fault_flags_pkg::MR_VERIFY_TO] = verifyTimeoutFlag;
      mirrorIn[fault_flags_pkg::MR_NEG_OV] = negativeSupplyOvervoltageFlag;
      mirrorIn[fault_flags_pkg::MR_TRISTATE] = outputTristateFlag;
   end

   // Next values of mirrors, edge history, message status, inhibit
   always_comb begin
      mirror_d = mirrorIn;
      enableValid_d = enableValid;
      lastMsgBad_d = lastMessageInvalid;
      inhibit_d = shootThroughInhibit;
   end

   // Mirror and status registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mirror_q <= '0;
         enableValid_q <= 1'b0; // No loss seen until valid first
         lastMsgBad_q <= 1'b0;
         shootThroughInhibit_q <= 1'b0;
      end else begin
         mirror_q <= mirror_d;
         enableValid_q <= enableValid_d;
         lastMsgBad_q <= lastMsgBad_d;
         shootThroughInhibit_q <= inhibit_d;
      end
   end

   // Word assembly; reserved bits stay zero
   always_comb begin
      wordRaw = '0;
      for (int i = 0; i < fault_flags_pkg::STICKY_NUM; i++) begin
         wordRaw[fault_flags_pkg::STICKY_POS[i]] = sticky_q[i];
      end
      for (int i = 0; i < fault_flags_pkg::MIRROR_NUM; i++) begin
         wordRaw[fault_flags_pkg::MIRROR_POS[i]] =
            mirror_q[i];
      end
      wordRaw[fault_flags_pkg::BIT_LAST_MSG] = lastMsgBad_q;
   end

   // Parity over the assembled word
   odd_parity uParity (
      .word(wordRaw[15:1]),
      .parity(wordParity)
   );

   // Live view of the register
   always_comb begin
      faultFlags_d = {wordRaw[15:1], wordParity};
   end

   // Read sequencing and answer word; a miss still carries the last-message bit and its parity
   always_comb begin
      rdState_d = rdState_q;
      rdData_d = rdData_q;
      rdValid_d = 1'b0;
      rdMiss_d = rdMiss_q;
      case (rdState_q)
         fault_flags_pkg::RD_IDLE: begin
            if (rdReq) begin
               rdState_d = fault_flags_pkg::RD_ANSWER;
               rdValid_d = 1'b1;
               if (rdAddr == fault_flags_pkg::FAULT_REG_OFFSET) begin
                  rdData_d = faultFlags_d;
                  rdMiss_d = 1'b0;
               end else begin
                  rdData_d = {14'h0000, lastMsgBad_q, ~lastMsgBad_q};
                  rdMiss_d = 1'b1;
               end
            end
         end
         fault_flags_pkg::RD_ANSWER: begin
            rdState_d = fault_flags_pkg::RD_IDLE;
         end
         default: begin
            rdState_d = fault_flags_pkg::RD_IDLE;
         end
      endcase
   end

   // Read and view registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdState_q <= fault_flags_pkg::RD_IDLE;
         rdData_q <= 16'h0000;
         rdValid_q <= 1'b0;
         rdMiss_q <= 1'b0;
         faultFlags_q <= 16'h0000;
      end else begin
         rdState_q <= rdState_d;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
         rdMiss_q <= rdMiss_d;
         faultFlags_q <= faultFlags_d;
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   reserved_bits_zero_a: assert property (
      rdValid_q && !rdMiss_q |->
         (rdData_q & fault_flags_pkg::RESERVED_MASK) == 16'h0000)
      else $error("reserved bit read nonzero");

   ov2_mirror_a: assert property (
      rdReq && rdState_q == fault_flags_pkg::RD_IDLE &&
      rdAddr == fault_flags_pkg::FAULT_REG_OFFSET |=>
         rdData_q[fault_flags_pkg::BIT_OV2_TO] ==
         $past(mirror_q[fault_flags_pkg::MR_OV2_TO]))
      else $error("overvoltage two timeout mirror wrong");

   blank_mirror_a: assert property (
      overvoltage2TimeoutFlag == 1'b0 && blankingTimeoutFlag |=>
         faultFlags_d[fault_flags_pkg::BIT_BLANK_TO] &&
         !faultFlags_d[fault_flags_pkg::BIT_OV2_TO])
      else $error("blanking timeout mirror wrong");

   ext_reset_set_a: assert property (
      extResetEvt |=> faultFlags_d[fault_flags_pkg::BIT_EXT_RESET] &&
         faultFlags_d[fault_flags_pkg::BIT_PRIM_RESET])
      else $error("external reset flag not set");

   any_reset_set_a: assert property (
      resetEvt |=> ##1 faultFlags_q[fault_flags_pkg::BIT_PRIM_RESET])
      else $error("reset flag not set");

   reset_value_a: assert property (
      $fell(rst) |-> (wordRaw & 16'hFFFC) == fault_flags_pkg::FAULT_REG_RESET)
      else $error("reset value wrong");

   enable_hold_a: assert property (
      faultFlags_d[fault_flags_pkg::BIT_ENABLE] && !enableValid |=>
         faultFlags_d[fault_flags_pkg::BIT_ENABLE])
      else $error("enable flag cleared while invalid");

   shoot_hold_a: assert property (
      sticky_q[fault_flags_pkg::SK_SHOOT] && shootThroughInhibit &&
      clearReq |=> sticky_q[fault_flags_pkg::SK_SHOOT])
      else $error("shoot-through flag cleared while inhibited");

   spi_set_a: assert property (
      spiFaultEvt && clearReq |=> sticky_q[fault_flags_pkg::SK_SPI])
      else $error("serial port flag lost");

   verify_mirror_a: assert property (
      ##1 faultFlags_d[fault_flags_pkg::BIT_VERIFY_TO] ==
         $past(verifyTimeoutFlag))
      else $error("verify timeout mirror wrong");

   neg_ov_mirror_a: assert property (
      $rose(negativeSupplyOvervoltageFlag) |=>
         $rose(faultFlags_d[fault_flags_pkg::BIT_NEG_OV]))
      else $error("negative supply mirror wrong");

   tristate_mirror_a: assert property (
      $fell(outputTristateFlag) |=> ##1
         !faultFlags_q[fault_flags_pkg::BIT_TRISTATE])
      else $error("tristate mirror wrong");

   link_hold_a: assert property (
      sticky_q[fault_flags_pkg::SK_LINK] && !secondaryReady |=>
         sticky_q[fault_flags_pkg::SK_LINK])
      else $error("link flag cleared while not ready");

   link_no_reset_a: assert property (
      !sticky_q[fault_flags_pkg::SK_LINK] && linkLossEvt && anyReset |=>
         !sticky_q[fault_flags_pkg::SK_LINK])
      else $error("reset set link loss flag");

   last_msg_bit_a: assert property (
      rdReq && rdState_q == fault_flags_pkg::RD_IDLE |=>
         rdValid_q && rdData_q[fault_flags_pkg::BIT_LAST_MSG] ==
         $past(lastMsgBad_q))
      else $error("last message bit wrong");

   odd_parity_a: assert property (
      rdValid_q |-> (^rdData_q) == 1'b1 && (^faultFlags_q) == 1'b1)
      else $error("parity not odd");

   inhibit_status_a: assert property (
      shootThroughInhibit [*2] |-> shootThroughInhibit_q)
      else $error("inhibit status wrong");

   sticky_keep_a: assert property (
      sticky_q[fault_flags_pkg::SK_SPI] && !clearReq |=>
         sticky_q[fault_flags_pkg::SK_SPI])
      else $error("sticky flag dropped without clear");

   read_hit_c: cover property (
      rdReq && rdAddr == fault_flags_pkg::FAULT_REG_OFFSET ##1 rdValid_q);
   clear_blocked_c: cover property (
      clearReq && sticky_q[fault_flags_pkg::SK_LINK] && !secondaryReady);
   clear_done_c: cover property (
      clearReq && sticky_q[fault_flags_pkg::SK_SPI] ##1
      !sticky_q[fault_flags_pkg::SK_SPI]);
   set_beats_clear_c: cover property (clearReq && spiFaultEvt);

endmodule : primary_fault_flags

//--- bench/host_reader.sv
/*
 * Host side model: issues register reads and clear commands.
 * Assumes the block answers a taken read one cycle later with a strobe.
 */
`timescale 1ns/1ns

module host_reader (
   // Clock
   input wire logic ref_clk,
   // Read port
   output logic rdReq,
   output logic [7:0] rdAddr,
   input wire logic [15:0] rdData_q,
   input wire logic rdValid_q,
   input wire logic rdMiss_q,
   // Clear command
   output logic clearReq
);
   initial begin
      rdReq = 1'b0;
      rdAddr = 8'hFF;
      clearReq = 1'b0;
   end

   // One read, held until the strobe is seen, bounded wait
   task automatic read_word(input logic [7:0] a, output logic [15:0] d,
                            output logic m);
      int n;
      n = 0;
      @(negedge ref_clk);
      rdReq = 1'b1;
      rdAddr = a;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (rdValid_q !== 1'b1 && n < 8);
      d = (rdValid_q === 1'b1) ? rdData_q : 16'hXXXX; // Lost answer fails
      m = (rdValid_q === 1'b1) ? rdMiss_q : 1'bX;
      @(negedge ref_clk);
      rdReq = 1'b0;
      rdAddr = ~a; // Released bus shows no stale address
   endtask : read_word

   // One-cycle clear command
   task automatic clear_flags();
      @(negedge ref_clk);
      clearReq = 1'b1;
      @(negedge ref_clk);
      clearReq = 1'b0;
   endtask : clear_flags
endmodule : host_reader

//--- bench/primary_fault_flags_tb_top.sv
/*
 * Testbench for the primary fault flag register.
 * Assumes the host model in host_reader.sv and the design package.
 */
`timescale 1ns/1ns
`define CHECK(nm, ex, got) \
   comparisons++; \
   if ((got) !== (ex)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
   end

module primary_fault_flags_tb_top;
   localparam logic [4:0] EV_RST = 5'h01;
   localparam logic [4:0] EV_EXT = 5'h02;
   localparam logic [4:0] EV_SHOOT = 5'h04;
   localparam logic [4:0] EV_SPI = 5'h08;
   localparam logic [4:0] EV_LINK = 5'h10;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] evt = 5'h00;
   logic [4:0] mir = 5'h00;
   logic enableValid = 1'b0;
   logic shootThroughInhibit = 1'b0;
   logic secondaryReady = 1'b1;
   logic lastMessageInvalid = 1'b0;
   logic rdReq, rdValid_q, rdMiss_q, clearReq, shootThroughInhibit_q;
   logic [7:0] rdAddr;
   logic [15:0] rdData_q, faultFlags_q, word;
   logic miss;
   logic [15:1] expFlags;
   int fails = 0;
   int comparisons = 0;

   // Clock and watchdog
   always #5 ref_clk = ~ref_clk;
   initial begin
      repeat (3000) @(posedge ref_clk);
      fails++;
      stop_test();
   end

   host_reader i_host (.ref_clk(ref_clk), .rdReq(rdReq), .rdAddr(rdAddr),
      .rdData_q(rdData_q), .rdValid_q(rdValid_q), .rdMiss_q(rdMiss_q),
      .clearReq(clearReq));

   primary_fault_flags i_dut (.ref_clk(ref_clk), .rst(rst),
      .rdReq(rdReq), .rdAddr(rdAddr), .rdData_q(rdData_q),
      .rdValid_q(rdValid_q), .rdMiss_q(rdMiss_q), .clearReq(clearReq),
      .resetEvt(evt[0]), .extResetEvt(evt[1]), .enableValid(enableValid),
      .shootThroughEvt(evt[2]), .shootThroughInhibit(shootThroughInhibit),
      .spiFaultEvt(evt[3]), .linkLossEvt(evt[4]),
      .secondaryReady(secondaryReady),
      .lastMessageInvalid(lastMessageInvalid),
      .overvoltage2TimeoutFlag(mir[fault_flags_pkg::MR_OV2_TO]),
      .blankingTimeoutFlag(mir[fault_flags_pkg::MR_BLANK_TO]),
      .verifyTimeoutFlag(mir[fault_flags_pkg::MR_VERIFY_TO]),
      .negativeSupplyOvervoltageFlag(mir[fault_flags_pkg::MR_NEG_OV]),
      .outputTristateFlag(mir[fault_flags_pkg::MR_TRISTATE]),
      .shootThroughInhibit_q(shootThroughInhibit_q),
      .faultFlags_q(faultFlags_q));

   // Expected word with odd parity in bit 0
   function automatic logic [15:0] word_of(input logic [15:1] f);
      return {f, ~^f};
   endfunction : word_of

   task automatic settle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : settle

   task automatic pulse(input logic [4:0] m);
      @(negedge ref_clk);
      evt = m;
      @(negedge ref_clk);
      evt = 5'h00;
   endtask : pulse

   // Read the register and compare against the expected flags
   task automatic rd_chk(input string nm);
      i_host.read_word(fault_flags_pkg::FAULT_REG_OFFSET, word, miss);
      `CHECK(nm, word_of(expFlags), word)
      `CHECK("miss", 1'b0, miss)
   endtask : rd_chk

   task automatic stop_test();
      $display("Checks %0d mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   // Test sequence
   initial begin
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      expFlags = '0;
      expFlags[fault_flags_pkg::BIT_PRIM_RESET] = 1'b1;
      rd_chk("reset value");
      settle(1);
      `CHECK("view", word_of(expFlags), faultFlags_q)
      i_host.clear_flags();
      expFlags = '0;
      rd_chk("cleared");
      $display("Test reset done");
      for (int i = 0; i < fault_flags_pkg::MIRROR_NUM; i++) begin
         @(negedge ref_clk);
         mir = 5'h00;
         mir[i] = 1'b1;
         settle(1);
         expFlags = '0;
         expFlags[fault_flags_pkg::MIRROR_POS[i]] = 1'b1;
         rd_chk("mirror");
      end
      @(negedge ref_clk);
      mir = 5'h00;
      settle(1);
      expFlags = '0;
      rd_chk("mirror off");
      $display("Test mirrors done");
      pulse(EV_SPI);
      expFlags[fault_flags_pkg::BIT_SPI_FAULT] = 1'b1;
      rd_chk("serial fault");
      pulse(EV_EXT);
      expFlags[fault_flags_pkg::BIT_EXT_RESET] = 1'b1;
      expFlags[fault_flags_pkg::BIT_PRIM_RESET] = 1'b1;
      rd_chk("pin reset");
      i_host.clear_flags();
      expFlags = '0;
      rd_chk("events cleared");
      pulse(EV_RST | EV_LINK);
      expFlags[fault_flags_pkg::BIT_PRIM_RESET] = 1'b1;
      rd_chk("reset no link");
      i_host.clear_flags();
      expFlags = '0;
      $display("Test events done");
      @(negedge ref_clk);
      enableValid = 1'b1;
      settle(2);
      enableValid = 1'b0;
      settle(2);
      expFlags[fault_flags_pkg::BIT_ENABLE] = 1'b1;
      rd_chk("enable lost");
      i_host.clear_flags();
      rd_chk("enable held");
      enableValid = 1'b1;
      i_host.clear_flags();
      expFlags = '0;
      rd_chk("enable cleared");
      $display("Test enable done");
      shootThroughInhibit = 1'b1;
      settle(1);
      `CHECK("inhibit", 1'b1, shootThroughInhibit_q)
      pulse(EV_SHOOT);
      expFlags[fault_flags_pkg::BIT_SHOOT] = 1'b1;
      rd_chk("shoot set");
      i_host.clear_flags();
      rd_chk("shoot held");
      settle(1);
      `CHECK("view", word_of(expFlags), faultFlags_q)
      shootThroughInhibit = 1'b0;
      settle(1);
      `CHECK("inhibit", 1'b0, shootThroughInhibit_q)
      i_host.clear_flags();
      expFlags = '0;
      rd_chk("shoot cleared");
      $display("Test shoot through done");
      secondaryReady = 1'b0;
      pulse(EV_LINK);
      expFlags[fault_flags_pkg::BIT_LINK_LOSS] = 1'b1;
      rd_chk("link lost");
      i_host.clear_flags();
      rd_chk("link held");
      secondaryReady = 1'b1;
      i_host.clear_flags();
      expFlags = '0;
      rd_chk("link cleared");
      $display("Test link done");
      lastMessageInvalid = 1'b1;
      settle(1);
      expFlags[fault_flags_pkg::BIT_LAST_MSG] = 1'b1;
      rd_chk("discarded");
      i_host.read_word(8'h04, word, miss);
      `CHECK("unmapped data", 16'h0002, word)
      `CHECK("unmapped miss", 1'b1, miss)
      $display("Test message status done");
      // Event and clear in one cycle: the set wins
      fork
         pulse(EV_SPI);
         i_host.clear_flags();
      join
      expFlags[fault_flags_pkg::BIT_SPI_FAULT] = 1'b1;
      rd_chk("set beats clear");
      // Second reset in mid-run
      rst = 1'b1;
      settle(2);
      rst = 1'b0;
      expFlags = '0;
      expFlags[fault_flags_pkg::BIT_PRIM_RESET] = 1'b1;
      expFlags[fault_flags_pkg::BIT_LAST_MSG] = 1'b1;
      rd_chk("second reset");
      $display("Test reset again done");
      stop_test();
   end
endmodule : primary_fault_flags_tb_top
